/* common/rtcs_pkg.sv */
// Purpose: shared constants for the clock bus and power supervisor block
// Assumes: one 250 MHz clock; timeouts counted in 32.768 kHz oscillator ticks
// Notes: byte addresses, field positions and time figures live here only
package rtcs_pkg;
	// byte addresses of the 16-byte map
	localparam logic [3:0] ADDR_SEC = 4'h0;
	localparam logic [3:0] ADDR_MIN = 4'h2;
	localparam logic [3:0] ADDR_HOUR = 4'h4;
	localparam logic [3:0] ADDR_DAY = 4'h6;
	localparam logic [3:0] ADDR_DOW = 4'h8;
	localparam logic [3:0] ADDR_MON = 4'h9;
	localparam logic [3:0] ADDR_YEAR = 4'hA;
	localparam logic [3:0] ADDR_RATES = 4'hB;
	localparam logic [3:0] ADDR_FLAGS = 4'hD;
	localparam logic [3:0] ADDR_CTRL = 4'hE;
	localparam logic [3:0] ADDR_CENT = 4'hF;
	// field positions
	localparam int CTRL_FREEZE_BIT = 3;
	localparam int CTRL_RUN_BIT = 2;
	localparam int RATE_WD_LSB = 4;
	localparam int FLAG_BVF_BIT = 0;
	// calendar reset values and limits (bcd)
	localparam logic [7:0] BCD_ZERO = 8'h00;
	localparam logic [7:0] BCD_ONE = 8'h01;
	localparam logic [7:0] BCD_59 = 8'h59;
	localparam logic [7:0] BCD_23 = 8'h23;
	localparam logic [7:0] BCD_7 = 8'h07;
	localparam logic [7:0] BCD_12 = 8'h12;
	localparam logic [7:0] BCD_99 = 8'h99;
	// timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int OSC_HZ = 32768;
	localparam int PB_MIN_NS = 1000;
	localparam int PB_MIN_CYCLES = (PB_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_HOLD_MS = 200;
	localparam int CER_MS = 200;
	localparam int CSR_MS = 200;
	localparam int WPT_US = 150;
	localparam int RST_HOLD_TICKS = RST_HOLD_MS * OSC_HZ / 1000;
	localparam int CER_TICKS = CER_MS * OSC_HZ / 1000;
	localparam int CSR_TICKS = CSR_MS * OSC_HZ / 1000;
	localparam int WPT_TICKS = (WPT_US * OSC_HZ / 1000000 > 0) ? WPT_US * OSC_HZ / 1000000 : 1;
	// reset sequencer states, gray along idle-button-hold
	typedef enum logic [1:0] {RS_IDLE = 2'b00, RS_BUTTON = 2'b01, RS_HOLD = 2'b11,
		RS_POWER = 2'b10} rtcs_rst_e;
	// writable bits per byte; the rest read as zero, except the battery flag bit of the flags byte
	function automatic logic [7:0] rtcs_wr_mask(input logic [3:0] a);
		case (a)
			4'h0, 4'h2: return 8'h7F;
			4'h4: return 8'hBF;
			4'h6: return 8'h3F;
			4'h8: return 8'h07;
			4'h9: return 8'h1F;
			4'hB: return 8'h7F;
			4'hC, 4'hE: return 8'h0F;
			4'hD: return 8'h00;
			default: return 8'hFF;
		endcase
	endfunction
	// watchdog timeout in oscillator ticks
	function automatic logic [16:0] rtcs_wd_ticks(input logic [2:0] s);
		case (s)
			3'd1: return 17'h0_0300;
			3'd2: return 17'h0_0600;
			3'd3: return 17'h0_0C00;
			3'd4: return 17'h0_1800;
			3'd5: return 17'h0_3000;
			3'd6: return 17'h0_6000;
			3'd7: return 17'h1_8000;
			default: return 17'h0_C000;
		endcase
	endfunction
	// reset pulse after watchdog expiry, oscillator ticks
	function automatic logic [16:0] rtcs_wd_rst_ticks(input logic [2:0] s);
		case (s)
			3'd1: return 17'h0_0080;
			3'd2: return 17'h0_0100;
			3'd3: return 17'h0_0200;
			3'd4: return 17'h0_0400;
			3'd5: return 17'h0_0800;
			3'd6: return 17'h0_1000;
			3'd7: return 17'h0_4000;
			default: return 17'h0_0008;
		endcase
	endfunction
endpackage

/* design/rtcs_top.sv */
// Purpose: sram-style byte port, time freeze/transfer, power supervisor, watchdog
// Assumes: all pins asynchronous to ref_clk; osc_clk_in is the 32.768 kHz time base
// Notes: hours count in 24-hour form; alarm and interrupt logic not present
`timescale 1ns/10ps

// Summary of operation
// [RULE1] read drives addressed byte when selected
// [RULE2] data lines released unless select and enable
// [RULE3] write starts at later falling strobe
// [RULE4] write ends, data taken, earlier rising strobe
// [RULE5] host holds address, observes recovery time
// [RULE6] host keeps write data set-up and hold
// [RULE7] write enable low releases driven outputs
// [RULE8] visible time bytes copied once per second
// [RULE9] freeze bit stops copies, counters keep running
// [RULE10] update in progress completes before freeze
// [RULE11] clearing freeze loads written time bytes
// [RULE12] run bit decides halt in backup only
// [RULE13] power fail blocks writes plus recovery time
// [RULE14] power fail forces sram enable inactive
// [RULE15] running sram access finishes, limit forces high
// [RULE16] sram enable held off after power-up
// [RULE17] valid power passes sram enable combinationally
// [RULE18] backup cell connected after first power-up
// [RULE19] reset low on power-down and hold time
// [RULE20] button pull starts long reset after release
// [RULE21] watchdog silence asserts watchdog and reset
// [RULE22] any watchdog edge restarts the count
// [RULE23] no valid battery clears watchdog rate
// [RULE24] supply inputs synchronised, timeouts in ticks
// [RULE25] strobes synchronised, writes committed at end
module rtcs_top
	import rtcs_pkg::*;
#(
	parameter int TICKS_PER_SEC = OSC_HZ,
	parameter int RST_TICKS = RST_HOLD_TICKS,
	parameter int CER_LIMIT = CER_TICKS,
	parameter int CSR_LIMIT = CSR_TICKS
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [3:0] addr,
	input wire logic cs_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [7:0] dq_in,
	output logic [7:0] dq_out,
	output logic dq_oe,
	input wire logic osc_clk_in,
	input wire logic power_fail_in,
	input wire logic switchover_threshold,
	input wire logic backup_cell_in,
	input wire logic ce_in_n,
	output logic ce_out_n,
	output logic sram_supply_out,
	output logic backup_connect,
	input wire logic rst_pin_in,
	output logic rst_pin_out,
	output logic rst_pin_oe,
	input wire logic watchdog_kick_in,
	output logic watchdog_expired_n
);
	localparam int NSYNC = 10;
	logic [NSYNC-1:0] pins, s1, s2, s3, filt;
	logic [11:0] ad1, ad2, ad3;
	logic f_cs_n, f_oe_n, f_we_n, f_osc, f_pf, f_so, f_bv, f_kick, f_rstp, f_ce_n;
	logic osc_q, tick, wr_q, wr_act, wr_end, wp, pf_q, power_back, kick_q, sec_tick, run;
	logic [3:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] vis [16];
	logic [7:0] cnt [16];
	logic [7:0] next_cnt [16];
	logic [16:0] sec_cnt, csr_cnt, cer_cnt, wpt_cnt, wd_cnt, hold_cnt, wd_limit;
	logic [8:0] pb_cnt;
	logic ce_block, wd_expire, commit, freeze, load, kick_edge;
	rtcs_rst_e state;

	// three-stage synchronisers for every pin
	assign pins = {cs_n, oe_n, we_n, osc_clk_in, power_fail_in, switchover_threshold,
		backup_cell_in, watchdog_kick_in, rst_pin_in, ce_in_n};
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s1 <= '1;
			s2 <= '1;
			s3 <= '1;
			ad1 <= '0;
			ad2 <= '0;
			ad3 <= '0;
		end else begin
			s1 <= pins;
			s2 <= s1;
			s3 <= s2;
			ad1 <= {addr, dq_in};
			ad2 <= ad1;
			ad3 <= ad2;
		end
	end
	// [RULE24] agreement filter per bit
	for (genvar i = 0; i < NSYNC; i++) begin : g_filt
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				filt[i] <= 1'b1;
			end else if (s2[i] == s3[i]) begin
				filt[i] <= s3[i];
			end
		end
	end
	assign {f_cs_n, f_oe_n, f_we_n, f_osc, f_pf, f_so, f_bv, f_kick, f_rstp, f_ce_n} = filt;

	// oscillator tick and one-second divider; clock halts only in backup with run at 0
	assign tick = f_osc & ~osc_q;
	// [RULE12] run gating
	assign run = ~f_so | vis[ADDR_CTRL][CTRL_RUN_BIT];
	assign sec_tick = tick & run & (sec_cnt == 17'(TICKS_PER_SEC - 1));
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			osc_q <= 1'b1;
			sec_cnt <= '0;
		end else begin
			osc_q <= f_osc;
			if (tick && run) begin
				sec_cnt <= sec_tick ? '0 : sec_cnt + 17'd1;
			end
		end
	end

	// host write strobes
	// [RULE3] start at later fall
	assign wr_act = ~f_cs_n & ~f_we_n;
	// [RULE4] end at earlier rise
	assign wr_end = wr_q & ~wr_act;
	// [RULE13] writes blocked while protected
	assign wp = f_pf | (csr_cnt != '0);
	// [RULE25] commit at strobe end
	assign commit = wr_end & ~wp;
	assign freeze = vis[ADDR_CTRL][CTRL_FREEZE_BIT];
	// [RULE11] freeze cleared loads counters
	assign load = commit & (wr_addr == ADDR_CTRL) & freeze & ~wr_data[CTRL_FREEZE_BIT];
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_q <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
		end else begin
			wr_q <= wr_act;
			if (wr_act) begin
				wr_addr <= ad3[11:8];
				wr_data <= ad3[7:0];
			end
		end
	end

	// read port: registered data and enable
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dq_out <= '0;
			dq_oe <= 1'b0;
		end else begin
			// [RULE1] addressed byte
			dq_out <= (ad3[11:8] == ADDR_FLAGS) ? 8'(f_bv) << FLAG_BVF_BIT : vis[ad3[11:8]];
			// [RULE2] [RULE7] release on deselect or write enable low
			dq_oe <= ~f_cs_n & ~f_oe_n & f_we_n;
		end
	end

	// bcd increment with wrap; bit 8 is the carry
	function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] last,
		input logic [7:0] first);
		if (v >= last) begin
			return {1'b1, first};
		end else if (v[3:0] == 4'h9) begin
			return {1'b0, v[7:4] + 4'h1, 4'h0};
		end
		return {1'b0, v[7:4], v[3:0] + 4'h1};
	endfunction
	// last day of month in bcd
	function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) :
			(y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		case (m)
			8'h02: return leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default: return 8'h31;
		endcase
	endfunction

	// calendar carry chain
	always_comb begin
		logic [8:0] r;
		r = '0;
		next_cnt = cnt;
		r = bcd_inc(cnt[ADDR_SEC], BCD_59, BCD_ZERO);
		next_cnt[ADDR_SEC] = r[7:0];
		if (r[8]) begin
			r = bcd_inc(cnt[ADDR_MIN], BCD_59, BCD_ZERO);
			next_cnt[ADDR_MIN] = r[7:0];
			if (r[8]) begin
				r = bcd_inc(cnt[ADDR_HOUR], BCD_23, BCD_ZERO);
				next_cnt[ADDR_HOUR] = r[7:0];
				if (r[8]) begin
					next_cnt[ADDR_DOW] = 8'(bcd_inc(cnt[ADDR_DOW], BCD_7, BCD_ONE));
					r = bcd_inc(cnt[ADDR_DAY], month_last(cnt[ADDR_MON], cnt[ADDR_YEAR]), BCD_ONE);
					next_cnt[ADDR_DAY] = r[7:0];
					if (r[8]) begin
						r = bcd_inc(cnt[ADDR_MON], BCD_12, BCD_ONE);
						next_cnt[ADDR_MON] = r[7:0];
						if (r[8]) begin
							r = bcd_inc(cnt[ADDR_YEAR], BCD_99, BCD_ZERO);
							next_cnt[ADDR_YEAR] = r[7:0];
							if (r[8]) begin
								next_cnt[ADDR_CENT] = 8'(bcd_inc(cnt[ADDR_CENT], BCD_99, BCD_ZERO));
							end
						end
					end
				end
			end
		end
	end

	// internal counters: load on unfreeze, else advance each second
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int k = 0; k < 16; k++) begin
				cnt[k] <= (k == ADDR_DAY || k == ADDR_DOW || k == ADDR_MON) ? BCD_ONE : BCD_ZERO;
			end
		end else if (load) begin
			cnt <= vis;
		end else if (sec_tick) begin
			cnt <= next_cnt;
		end
	end

	// visible bytes: copy then host write, write taking the byte it names
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int k = 0; k < 16; k++) begin
				vis[k] <= (k == ADDR_DAY || k == ADDR_DOW || k == ADDR_MON) ? BCD_ONE : BCD_ZERO;
			end
		end else begin
			// [RULE8] [RULE9] [RULE10] simultaneous copy unless already frozen
			if (sec_tick && !freeze) begin
				for (int k = 0; k <= ADDR_YEAR; k++) begin
					if (k == ADDR_SEC || k == ADDR_MIN || k == ADDR_HOUR || k >= ADDR_DAY && k[0] == 1'b0
						|| k == ADDR_MON || k == ADDR_YEAR) begin
						vis[k] <= next_cnt[k];
					end
				end
				vis[ADDR_CENT] <= next_cnt[ADDR_CENT];
			end
			if (commit) begin
				vis[wr_addr] <= wr_data & rtcs_wr_mask(wr_addr);
			end
			// [RULE23] default watchdog rate without battery
			if (power_back && !f_bv) begin
				vis[ADDR_RATES][RATE_WD_LSB +: 3] <= 3'b000;
			end
		end
	end

	// power-fail protection, sram enable gating and backup connection
	assign power_back = pf_q & ~f_pf;
	// [RULE14] [RULE16] [RULE17] combinational pass-through, gated by block flag
	assign ce_out_n = ce_in_n | ce_block;
	assign sram_supply_out = f_so & backup_connect;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pf_q <= 1'b1;
			csr_cnt <= '0;
			cer_cnt <= '0;
			wpt_cnt <= '0;
			ce_block <= 1'b1;
			backup_connect <= 1'b0;
		end else begin
			pf_q <= f_pf;
			// [RULE13] recovery after supply returns
			if (f_pf) begin
				csr_cnt <= 17'(CSR_LIMIT);
			end else if (tick && csr_cnt != '0) begin
				csr_cnt <= csr_cnt - 17'd1;
			end
			// [RULE18] first valid power breaks isolation
			if (power_back) begin
				backup_connect <= 1'b1;
			end
			if (f_pf) begin
				cer_cnt <= 17'(CER_LIMIT);
				if (!pf_q) begin
					wpt_cnt <= 17'(WPT_TICKS);
				end else if (tick && wpt_cnt != '0) begin
					wpt_cnt <= wpt_cnt - 17'd1;
				end
				// [RULE15] finish access or force at limit
				if (f_ce_n || (pf_q && wpt_cnt == '0)) begin // limit loads on first fail cycle
					ce_block <= 1'b1;
				end
			end else if (cer_cnt != '0) begin
				// [RULE16] power-up hold
				ce_block <= 1'b1;
				if (tick) begin
					cer_cnt <= cer_cnt - 17'd1;
				end
			end else begin
				ce_block <= ~backup_connect;
			end
		end
	end

	// watchdog: any edge restarts, expiry repeats every period; a kick beats expiry
	assign kick_edge = f_kick ^ kick_q;
	assign wd_limit = rtcs_wd_ticks(vis[ADDR_RATES][RATE_WD_LSB +: 3]);
	assign wd_expire = ~f_pf & ~kick_edge & tick & (wd_cnt == wd_limit - 17'd1);
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			kick_q <= 1'b1;
			wd_cnt <= '0;
			watchdog_expired_n <= 1'b1;
		end else begin
			kick_q <= f_kick;
			// [RULE22] edge restarts count
			if (f_pf || kick_edge) begin
				wd_cnt <= '0;
				watchdog_expired_n <= 1'b1;
			end else if (wd_expire) begin
				// [RULE21] expiry drives watchdog output
				wd_cnt <= '0;
				watchdog_expired_n <= 1'b0;
			end else if (tick) begin
				wd_cnt <= wd_cnt + 17'd1;
			end
		end
	end

	// reset sequencer: power, push-button and watchdog sources
	assign rst_pin_out = 1'b0;
	assign rst_pin_oe = (state == RS_POWER) || (state == RS_HOLD);
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= RS_POWER;
			hold_cnt <= '0;
			pb_cnt <= '0;
		end else begin
			case (state)
				RS_IDLE: begin
					pb_cnt <= f_rstp ? '0 : pb_cnt + 9'd1;
					if (f_pf) begin
						state <= RS_POWER;
					end else if (wd_expire) begin
						state <= RS_HOLD;
						hold_cnt <= rtcs_wd_rst_ticks(vis[ADDR_RATES][RATE_WD_LSB +: 3]);
					end else if (pb_cnt == 9'(PB_MIN_CYCLES - 1) && !f_rstp) begin
						// [RULE20] long enough pull seen
						state <= RS_BUTTON;
					end
				end
				RS_BUTTON: begin
					pb_cnt <= '0;
					if (f_pf) begin
						state <= RS_POWER;
					end else if (f_rstp) begin
						// [RULE20] hold after release
						state <= RS_HOLD;
						hold_cnt <= 17'(RST_TICKS);
					end
				end
				RS_HOLD: begin
					if (f_pf) begin
						state <= RS_POWER;
					end else if (tick) begin
						if (hold_cnt <= 17'd1) begin
							state <= RS_IDLE;
						end
						hold_cnt <= hold_cnt - 17'd1;
					end
				end
				RS_POWER: begin
					// [RULE19] hold time after supply returns
					if (!f_pf) begin
						state <= RS_HOLD;
						hold_cnt <= 17'(RST_TICKS);
					end
				end
				default: state <= RS_POWER;
			endcase
		end
	end

	sequence s_read_sel;
		!f_cs_n && !f_oe_n && f_we_n;
	endsequence
	sequence s_write_done;
		commit;
	endsequence
	property p_read_drive;
		@(posedge ref_clk) disable iff (rst) s_read_sel |=>
			dq_oe && (dq_out == $past(vis[ad3[11:8]]) || $past(ad3[11:8]) == ADDR_FLAGS);
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read byte not driven"); // [RULE1]
	property p_hiz;
		@(posedge ref_clk) disable iff (rst) f_cs_n |=> !dq_oe;
	endproperty
	a_hiz: assert property (p_hiz) else $error("data driven while deselected"); // [RULE2]
	property p_commit;
		@(posedge ref_clk) disable iff (rst) s_write_done |=>
			vis[$past(wr_addr)] == $past(wr_data & rtcs_wr_mask(wr_addr));
	endproperty
	a_commit: assert property (p_commit) else $error("write not captured at end"); // [RULE4]
	property p_we_release;
		@(posedge ref_clk) disable iff (rst) !f_we_n |=> !dq_oe;
	endproperty
	a_we_release: assert property (p_we_release) else $error("outputs kept during write"); // [RULE7]
	property p_copy;
		@(posedge ref_clk) disable iff (rst) sec_tick && !freeze && !commit |=>
			vis[ADDR_SEC] == cnt[ADDR_SEC];
	endproperty
	a_copy: assert property (p_copy) else $error("second byte not updated"); // [RULE8]
	property p_frozen;
		@(posedge ref_clk) disable iff (rst) freeze && !commit |=> $stable(vis[ADDR_SEC]);
	endproperty
	a_frozen: assert property (p_frozen) else $error("visible byte changed while frozen"); // [RULE9]
	property p_protect;
		@(posedge ref_clk) disable iff (rst) wp && wr_end && !sec_tick && !power_back |=>
			$stable(vis[wr_addr]);
	endproperty
	a_protect: assert property (p_protect) else $error("write accepted while protected"); // [RULE13]
	property p_ce_pass;
		@(posedge ref_clk) disable iff (rst) f_pf && (f_ce_n || pf_q && wpt_cnt == '0) |=>
			ce_out_n;
	endproperty
	a_ce_pass: assert property (p_ce_pass) else $error("sram enable not forced off"); // [RULE14]
	property p_ce_follow;
		@(posedge ref_clk) disable iff (rst) !f_pf && cer_cnt == '0 && backup_connect |=>
			ce_out_n == ce_in_n;
	endproperty
	a_ce_follow: assert property (p_ce_follow) else $error("sram enable not passed"); // [RULE17]
	property p_rst_power;
		@(posedge ref_clk) disable iff (rst) f_pf |-> ##[1:2] rst_pin_oe;
	endproperty
	a_rst_power: assert property (p_rst_power) else $error("no reset on power fail"); // [RULE19]
	property p_wd;
		@(posedge ref_clk) disable iff (rst) wd_expire && state == RS_IDLE |=>
			!watchdog_expired_n && rst_pin_oe;
	endproperty
	a_wd: assert property (p_wd) else $error("watchdog expiry not signalled"); // [RULE21]
endmodule // rtcs_top

/* bench/rtcs_host_model.sv */
// Purpose: host bus master for the clock supervisor
// Assumes: strobes move on the falling edge of ref_clk, well inside sync latency
// Notes: a released data bus shows a changing pattern, never the last value
`timescale 1ns/10ps
module rtcs_host_model (
	input wire logic ref_clk,
	output logic [3:0] addr,
	output logic cs_n,
	output logic oe_n,
	output logic we_n,
	output logic [7:0] dq_in,
	input wire logic [7:0] dq_out,
	input wire logic dq_oe
);
	logic drv = 1'b0;
	logic [7:0] wdat = 8'h00;
	logic [7:0] junk = 8'h5a;
	// idle bus at time zero
	initial begin
		addr = 4'h0;
		cs_n = 1'b1;
		oe_n = 1'b1;
		we_n = 1'b1;
	end
	// floating lines change every cycle so stale data cannot match
	always @(negedge ref_clk) begin
		junk <= ~junk;
	end
	// bus level: host data, else device data, else floating pattern
	always_comb begin
		dq_in = drv ? wdat : (dq_oe ? dq_out : junk);
	end
	// address and data held, output enable high
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		addr <= a;
		wdat <= d;
		drv <= 1'b1;
		cs_n <= 1'b0;
		repeat (2) @(negedge ref_clk);
		we_n <= 1'b0;
		repeat (10) @(negedge ref_clk);
		we_n <= 1'b1;
		repeat (2) @(negedge ref_clk);
		cs_n <= 1'b1;
		repeat (8) @(negedge ref_clk);
		drv <= 1'b0;
	endtask
	// plain read, strobes high long enough afterwards
	task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic o);
		@(negedge ref_clk);
		addr <= a;
		cs_n <= 1'b0;
		oe_n <= 1'b0;
		repeat (10) @(negedge ref_clk);
		d = dq_out;
		o = dq_oe;
		cs_n <= 1'b1;
		oe_n <= 1'b1;
		repeat (6) @(negedge ref_clk);
	endtask
	// careless host: write enable falls while outputs are on
	task automatic rd_wr(input logic [3:0] a, input logic [7:0] d, output logic o1,
		output logic o2);
		@(negedge ref_clk);
		addr <= a;
		wdat <= d;
		cs_n <= 1'b0;
		oe_n <= 1'b0;
		repeat (10) @(negedge ref_clk);
		o1 = dq_oe;
		drv <= 1'b1;
		we_n <= 1'b0;
		repeat (10) @(negedge ref_clk);
		o2 = dq_oe;
		we_n <= 1'b1;
		cs_n <= 1'b1;
		oe_n <= 1'b1;
		repeat (8) @(negedge ref_clk);
		drv <= 1'b0;
	endtask
endmodule // rtcs_host_model

/* bench/rtc_bus_and_power_supervisor_bench.sv */
// Purpose: self-checking bench for the clock bus and power supervisor
// Assumes: shortened counts; one oscillator tick every 10 ref_clk cycles
// Notes: random bytes from a fixed seed; expectations from local tables
`timescale 1ns/10ps
module rtc_bus_and_power_supervisor_bench import rtcs_pkg::*; ();
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr, a;
	logic cs_n, oe_n, we_n, dq_oe, ok, oe1, oe2;
	logic [7:0] dq_in, dq_out, got, d, s0, s1;
	logic osc_clk_in = 1'b0, power_fail_in = 1'b0, switchover_threshold = 1'b0;
	logic backup_cell_in = 1'b1, ce_in_n = 1'b0, btn = 1'b0, watchdog_kick_in = 1'b0;
	logic ce_out_n, sram_supply_out, backup_connect, rst_pin_in, rst_pin_out, rst_pin_oe;
	logic watchdog_expired_n;
	int failures = 0, checked = 0, cyc = 0, oc = 0, r;
	integer seed = 32'hc040_1a9f;
	// clock and open-drain reset wire with pull-up
	always #2 ref_clk = ~ref_clk;
	assign rst_pin_in = ~btn & ~(rst_pin_oe & ~rst_pin_out);
	// oscillator: toggles every 5 cycles
	always @(negedge ref_clk) begin
		if (oc == 4) begin
			oc <= 0;
			osc_clk_in <= ~osc_clk_in;
		end else
			oc <= oc + 1;
	end
	// hang guard
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failures++;
			conclude();
		end
	end
	rtcs_top #(.TICKS_PER_SEC(8), .RST_TICKS(4), .CER_LIMIT(4), .CSR_LIMIT(4)) i_dut (
		.ref_clk, .rst, .addr, .cs_n, .oe_n, .we_n, .dq_in, .dq_out, .dq_oe, .osc_clk_in,
		.power_fail_in, .switchover_threshold, .backup_cell_in, .ce_in_n, .ce_out_n,
		.sram_supply_out, .backup_connect, .rst_pin_in, .rst_pin_out, .rst_pin_oe,
		.watchdog_kick_in, .watchdog_expired_n);
	rtcs_host_model i_host (.ref_clk, .addr, .cs_n, .oe_n, .we_n, .dq_in, .dq_out, .dq_oe);
	// writable bits of each byte other than rates and control
	function automatic logic [7:0] msk(input logic [3:0] x);
		case (x)
			4'h0, 4'h2: return 8'h7f;
			4'h4: return 8'hbf;
			4'h6: return 8'h3f;
			4'h8: return 8'h07;
			4'h9: return 8'h1f;
			4'hc: return 8'h0f;
			4'hd: return 8'h00;
			default: return 8'hff;
		endcase
	endfunction
	function automatic int bcd(input logic [7:0] v);
		return v[7:4] * 10 + v[3:0];
	endfunction
	task automatic wt(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
		checked++;
		if (s !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic chk1(input string n, input logic e, input logic s);
		checked++;
		if (s !== e) begin
			failures++;
			$display("wrong value %s expected %b seen %b", n, e, s);
		end
	endtask
	task automatic conclude;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// main sequence
	initial begin
		wt(8);
		chk1("ce_out_n reset", 1'b1, ce_out_n);
		chk1("backup_connect reset", 1'b0, backup_connect);
		chk1("rst_pin_oe reset", 1'b1, rst_pin_oe);
		chk1("rst_pin_out low", 1'b0, rst_pin_out);
		rst <= 1'b0;
		wt(20);
		chk1("ce_out_n hold", 1'b1, ce_out_n);
		chk1("rst_pin_oe hold", 1'b1, rst_pin_oe);
		wt(100);
		chk1("ce_out_n pass", 1'b0, ce_out_n);
		chk1("backup_connect", 1'b1, backup_connect);
		chk1("rst_pin_oe end", 1'b0, rst_pin_oe);
		// random bytes with visible copies frozen
		i_host.wr(ADDR_CTRL, 8'h08);
		repeat (12) begin
			r = $random(seed);
			a = r[3:0];
			d = r[11:4];
			if (a == ADDR_RATES || a == ADDR_CTRL)
				a = 4'hc;
			i_host.wr(a, d);
			i_host.rd(a, got, ok);
			chk8("byte", (d & msk(a)) | {7'h00, a == ADDR_FLAGS}, got);
			chk1("dq_oe read", 1'b1, ok);
			wt(4);
			chk1("dq_oe idle", 1'b0, dq_oe);
		end
		// freeze holds seconds, release loads and resumes
		i_host.wr(ADDR_SEC, 8'h30);
		wt(240);
		i_host.rd(ADDR_SEC, got, ok);
		chk8("frozen sec", 8'h30, got);
		i_host.wr(ADDR_CTRL, 8'h00);
		wt(100);
		i_host.rd(ADDR_SEC, s0, ok);
		chk1("sec loaded", 1'b1, s0 == 8'h31 || s0 == 8'h32);
		wt(63);
		i_host.rd(ADDR_SEC, s1, ok);
		chk8("sec step", s0 + 8'h01, s1);
		// backup mode stops the clock unless the run bit is set
		for (int run = 0; run < 2; run++) begin
			i_host.wr(ADDR_CTRL, run ? 8'h04 : 8'h00);
			i_host.rd(ADDR_SEC, s0, ok);
			switchover_threshold <= 1'b1;
			wt(40);
			chk1("sram_supply_out", 1'b1, sram_supply_out);
			wt(200);
			switchover_threshold <= 1'b0;
			i_host.rd(ADDR_SEC, s1, ok);
			chk1("runs in backup", run[0], (bcd(s1) - bcd(s0) + 60) % 60 > 1);
		end
		// write enable falling releases a driven bus
		i_host.rd_wr(4'hc, 8'h0a, oe1, oe2);
		chk1("dq_oe before", 1'b1, oe1);
		chk1("dq_oe after", 1'b0, oe2);
		// power fail with an sram access open and no battery
		i_host.wr(ADDR_RATES, 8'h70);
		backup_cell_in <= 1'b0;
		power_fail_in <= 1'b1;
		wt(10);
		chk1("ce_out_n access", 1'b0, ce_out_n);
		wt(80);
		chk1("ce_out_n limit", 1'b1, ce_out_n);
		chk1("rst_pin_oe fail", 1'b1, rst_pin_oe);
		ce_in_n <= 1'b1;
		wt(2);
		ce_in_n <= 1'b0;
		wt(10);
		chk1("ce_out_n forced", 1'b1, ce_out_n);
		i_host.wr(4'hc, 8'h05);
		power_fail_in <= 1'b0;
		i_host.wr(4'hc, 8'h03);
		chk1("ce_out_n power-up", 1'b1, ce_out_n);
		wt(100);
		chk1("ce_out_n valid", 1'b0, ce_out_n);
		chk1("rst_pin_oe released", 1'b0, rst_pin_oe);
		i_host.rd(4'hc, got, ok);
		chk8("blocked write", 8'h0a, got);
		i_host.rd(ADDR_RATES, got, ok);
		chk8("rates cleared", 8'h00, got);
		backup_cell_in <= 1'b1;
		// sram enable passes straight through
		repeat (6) begin
			r = $random(seed);
			ce_in_n = r[0];
			#1 chk1("ce_out_n comb", ce_in_n, ce_out_n);
			wt(1);
		end
		// short pull ignored, long pull starts a reset
		for (int n = 100; n < 400; n += 200) begin
			btn <= 1'b1;
			wt(n);
			btn <= 1'b0;
			wt(20);
			chk1("button reset", n > 250, rst_pin_oe);
			wt(100);
			chk1("button end", 1'b0, rst_pin_oe);
		end
		// kicks keep the watchdog quiet, silence trips it
		i_host.wr(ADDR_RATES, 8'h10);
		repeat (5) begin
			wt(2000);
			watchdog_kick_in <= ~watchdog_kick_in;
		end
		chk1("wd kicked", 1'b1, watchdog_expired_n);
		wt(7000);
		chk1("wd early", 1'b1, watchdog_expired_n);
		wt(1000);
		chk1("wd expired", 1'b0, watchdog_expired_n);
		chk1("wd reset", 1'b1, rst_pin_oe);
		watchdog_kick_in <= ~watchdog_kick_in;
		wt(20);
		chk1("wd cleared", 1'b1, watchdog_expired_n);
		conclude();
	end
endmodule // rtc_bus_and_power_supervisor_bench
